/* hdl/vgatg_consts.vh */
// constants for the 640x480 raster timing generator
// assumes a 25 MHz pixel clock on i_clock
`ifndef VGATG_CONSTS_VH
`define VGATG_CONSTS_VH
`define VGATG_CLK_HZ        25000000
`define VGATG_H_VISIBLE     10'h280
`define VGATG_H_PRE_BLANK   10'h010
`define VGATG_H_PULSE       10'h060
`define VGATG_H_POST_BLANK  10'h030
`define VGATG_H_TOTAL       10'h320
`define VGATG_V_VISIBLE     10'h1E0
`define VGATG_V_PRE_BLANK   10'h00A
`define VGATG_V_PULSE       10'h002
`define VGATG_V_POST_BLANK  10'h01D
`define VGATG_V_TOTAL       10'h209
`define VGATG_CNT_RESET     10'h000
`endif

/* hdl/vgatg_top.v */
// raster timing generator: 640x480, pixel and row counters, syncs, colour gate
// assumes i_clock is the 25 MHz pixel clock and colour data arrives same-clock
`timescale 1ns/10ps
`default_nettype none
`include "vgatg_consts.vh"
module vgatg_top #(
  parameter CW = 4                                 // bits per colour channel
) (
  input  wire          i_clock,                    // pixel clock, 25 MHz
  input  wire          i_nrst,                     // async reset, active low
  input  wire          i_mono_mode,                // three-bit colour mode
  input  wire [CW-1:0] i_red,                      // red pixel value
  input  wire [CW-1:0] i_green,                    // green pixel value
  input  wire [CW-1:0] i_blue,                     // blue pixel value
  output wire [9:0]    o_pixel_x,                  // pixel address
  output wire [9:0]    o_pixel_y,                  // row address
  output wire          o_active,                   // position is visible
  output reg           o_line_sync_pulse_n,        // line sync, active low
  output reg           o_frame_sync_pulse_n,       // frame sync, active low
  output reg  [CW-1:0] o_red,                      // red to ladder
  output reg  [CW-1:0] o_green,                    // green to ladder
  output reg  [CW-1:0] o_blue                      // blue to ladder
);
  // phase codes shared by both axes
  localparam [1:0] PH_VISIBLE    = 2'b00;
  localparam [1:0] PH_PRE_BLANK  = 2'b01;
  localparam [1:0] PH_PULSE      = 2'b10;
  localparam [1:0] PH_POST_BLANK = 2'b11;

  // pixel and row counters
  reg  [9:0]    h_q;
  reg  [9:0]    h_d;
  reg  [9:0]    v_q;
  reg  [9:0]    v_d;
  // phase of each axis, following its counter
  reg  [1:0]    h_phase_q;
  reg  [1:0]    h_phase_d;
  reg  [1:0]    v_phase_q;
  reg  [1:0]    v_phase_d;
  // decoded syncs, visibility and gated colour
  reg           line_sync_d;
  reg           frame_sync_d;
  reg           h_visible;
  reg           v_visible;
  reg  [CW-1:0] red_d;
  reg  [CW-1:0] green_d;
  reg  [CW-1:0] blue_d;
  wire          h_last;
  wire          v_last;
  wire          line_step;

  // true on the final count of a period
  function vgatg_is_last;
    input [9:0] cnt;
    input [9:0] total;
    begin
      vgatg_is_last = (cnt == total - 10'h001);
    end
  endfunction

  // next count, wrapping after the final count
  function [9:0] vgatg_step;
    input [9:0] cnt;
    input [9:0] total;
    begin
      if (vgatg_is_last(cnt, total)) begin
        vgatg_step = `VGATG_CNT_RESET;
      end else begin
        vgatg_step = cnt + 10'h001;
      end
    end
  endfunction

  // visible, pre-sync blank, pulse or post-sync blank for a count
  function [1:0] vgatg_phase;
    input [9:0] cnt;
    input [9:0] vis;
    input [9:0] pre;
    input [9:0] pw;
    reg   [9:0] sync_first;
    reg   [9:0] sync_end;
    begin
      sync_first = vis + pre;
      sync_end   = sync_first + pw;
      if (cnt < vis) begin
        vgatg_phase = PH_VISIBLE;
      end else if (cnt < sync_first) begin
        vgatg_phase = PH_PRE_BLANK;
      end else if (cnt < sync_end) begin
        vgatg_phase = PH_PULSE;
      end else begin
        vgatg_phase = PH_POST_BLANK;
      end
    end
  endfunction

  // channel value, msb copied to all bits in three-bit mode
  function [CW-1:0] vgatg_chan;
    input [CW-1:0] val;
    input          mono;
    begin
      if (mono) begin
        vgatg_chan = {CW{val[CW-1]}};
      end else begin
        vgatg_chan = val;
      end
    end
  endfunction

  assign h_last    = vgatg_is_last(h_q, `VGATG_H_TOTAL);
  assign v_last    = vgatg_is_last(v_q, `VGATG_V_TOTAL);
  // row steps at the line end, a fixed offset from the line sync
  assign line_step = h_last;
  assign o_pixel_x = h_q;
  assign o_pixel_y = v_q;
  assign o_active  = h_visible && v_visible;

  // pixel counter, free running on the pixel clock
  always @* begin
    h_d = vgatg_step(h_q, `VGATG_H_TOTAL);
  end

  // row counter, one step per line
  always @* begin
    v_d = v_q;
    if (line_step) begin
      v_d = vgatg_step(v_q, `VGATG_V_TOTAL);
    end
  end

  // horizontal phase of the next count
  always @* begin
    h_phase_d = vgatg_phase(h_d,
                            `VGATG_H_VISIBLE,
                            `VGATG_H_PRE_BLANK,
                            `VGATG_H_PULSE);
  end

  // vertical phase of the next count
  always @* begin
    v_phase_d = vgatg_phase(v_d,
                            `VGATG_V_VISIBLE,
                            `VGATG_V_PRE_BLANK,
                            `VGATG_V_PULSE);
  end

  // horizontal decode: visibility and line sync
  always @* begin
    h_visible   = 1'b0;
    line_sync_d = 1'b1;
    case (h_phase_q)
      PH_VISIBLE: begin
        h_visible = 1'b1;
      end
      PH_PRE_BLANK: begin
        h_visible = 1'b0;
      end
      PH_PULSE: begin
        line_sync_d = 1'b0;
      end
      PH_POST_BLANK: begin
        h_visible = 1'b0;
      end
      default: begin
        h_visible   = 1'b0;
        line_sync_d = 1'b1;
      end
    endcase
  end

  // vertical decode: visibility and frame sync
  always @* begin
    v_visible    = 1'b0;
    frame_sync_d = 1'b1;
    case (v_phase_q)
      PH_VISIBLE: begin
        v_visible = 1'b1;
      end
      PH_PRE_BLANK: begin
        v_visible = 1'b0;
      end
      PH_PULSE: begin
        frame_sync_d = 1'b0;
      end
      PH_POST_BLANK: begin
        v_visible = 1'b0;
      end
      default: begin
        v_visible    = 1'b0;
        frame_sync_d = 1'b1;
      end
    endcase
  end

  // red gate: zero outside the visible region
  always @* begin
    red_d = {CW{1'b0}};
    if (o_active) begin
      red_d = vgatg_chan(i_red, i_mono_mode);
    end
  end

  // green gate
  always @* begin
    green_d = {CW{1'b0}};
    if (o_active) begin
      green_d = vgatg_chan(i_green, i_mono_mode);
    end
  end

  // blue gate
  always @* begin
    blue_d = {CW{1'b0}};
    if (o_active) begin
      blue_d = vgatg_chan(i_blue, i_mono_mode);
    end
  end

  // pixel counter register, reset to the first visible pixel
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      h_q <= `VGATG_CNT_RESET;
    end else begin
      h_q <= h_d;
    end
  end

  // row counter register
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      v_q <= `VGATG_CNT_RESET;
    end else begin
      v_q <= v_d;
    end
  end

  // horizontal phase register, always matching h_q
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      h_phase_q <= PH_VISIBLE;
    end else begin
      h_phase_q <= h_phase_d;
    end
  end

  // vertical phase register, always matching v_q
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      v_phase_q <= PH_VISIBLE;
    end else begin
      v_phase_q <= v_phase_d;
    end
  end

  // line sync, one clock behind the counter like the colour
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_line_sync_pulse_n <= 1'b1;
    end else begin
      o_line_sync_pulse_n <= line_sync_d;
    end
  end

  // frame sync, same alignment as the line sync
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_frame_sync_pulse_n <= 1'b1;
    end else begin
      o_frame_sync_pulse_n <= frame_sync_d;
    end
  end

  // red output register
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_red <= {CW{1'b0}};
    end else begin
      o_red <= red_d;
    end
  end

  // green output register
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_green <= {CW{1'b0}};
    end else begin
      o_green <= green_d;
    end
  end

  // blue output register
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_blue <= {CW{1'b0}};
    end else begin
      o_blue <= blue_d;
    end
  end
endmodule // vgatg_top
`default_nettype wire

/* bench/vgatg_checker.sv */
// assertions on vgatg_top ports, bound below
`timescale 1ns/10ps
`default_nettype none
module vgatg_checker #(parameter CW = 4) (
  input wire logic i_clock, i_nrst, i_mono_mode, o_active, o_line_sync_pulse_n,
  input wire logic o_frame_sync_pulse_n,
  input wire logic [CW-1:0] i_red, o_red,
  input wire logic [9:0] o_pixel_x, o_pixel_y
);
  wire [9:0] x = o_pixel_x;
  wire [9:0] y = o_pixel_y;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence s_eol; x == 799; endsequence
  a_x_wrap: assert property (s_eol |=> x == 0) else $error("x wrap");
  a_x_step: assert property (x != 799 |=> x == $past(x) + 1) else $error("x step");
  a_y_step: assert property (s_eol ##0 y != 520 |=> y == $past(y) + 1) else $error("y");
  a_y_wrap: assert property (s_eol ##0 y == 520 |=> y == 0) else $error("y wrap");
  a_act_map: assert property (o_active == (x < 640 && y < 480)) else $error("act");
  a_hs_win: assert property (o_line_sync_pulse_n == !($past(x) inside {[656:751]}))
    else $error("hs");
  a_vs_win: assert property (o_frame_sync_pulse_n == !($past(y) inside {[490:491]}))
    else $error("vs");
  a_blank_red: assert property (!$past(o_active) |-> o_red == 0) else $error("blank");
  a_mono_red: assert property ($past(o_active) && $past(i_mono_mode) |->
    o_red == {CW{$past(i_red[CW-1])}}) else $error("mono");
endmodule // vgatg_checker
bind vgatg_top vgatg_checker #(.CW(CW)) chk_u (.*);
`default_nettype wire

/* bench/vgatg_monitor.sv */
// display-side model: line sync width and period
`timescale 1ns/10ps
`default_nettype none
module vgatg_monitor (input wire logic i_clock, i_hs_n, output var logic [9:0] o_low, o_period);
  logic [9:0] cnt_q;
  logic       prev_q;
  always @(posedge i_clock) begin
    prev_q <= i_hs_n;
    cnt_q <= (prev_q & !i_hs_n) ? 10'h001 : cnt_q + 10'h001;
    if (prev_q & !i_hs_n) o_period <= cnt_q;
    if (!i_hs_n) o_low <= prev_q ? 10'h001 : o_low + 10'h001;
  end
endmodule // vgatg_monitor
`default_nettype wire

/* bench/tb_vgatg_top.sv */
// bench: vgatg_top with display monitor
`timescale 1ns/10ps
`default_nettype none
module tb_vgatg_top;
  logic i_clock = 0, i_nrst = 0, i_mono_mode = 0, hs_n, vs_n, act;
  logic [3:0] i_red = 4'h9, i_green = 4'h6, i_blue = 4'h3, r, g, b;
  logic [9:0] x, y, lo, per;
  int errors = 0, checks = 0;
  always #20 i_clock = ~i_clock;
  vgatg_top dut_u (.i_clock, .i_nrst, .i_mono_mode, .i_red, .i_green, .i_blue, .o_pixel_x(x),
    .o_pixel_y(y), .o_active(act), .o_line_sync_pulse_n(hs_n), .o_frame_sync_pulse_n(vs_n),
    .o_red(r), .o_green(g), .o_blue(b));
  vgatg_monitor mon_u (.i_clock, .i_hs_n(hs_n), .o_low(lo), .o_period(per));
  task chk(input logic [9:0] a, e);
    checks++;
    if (a !== e) begin errors++; $display("[FAIL] %0t %h %h", $time, a, e); end
  endtask
  task conclude;
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task t_line;
    repeat (2400) @(negedge i_clock);
    chk(per, 10'h320);
    chk(lo, 10'h060);
    chk(y, 10'h003);
    chk({9'h000, act}, 10'h001);
    chk({9'h000, vs_n}, 10'h001);
  endtask
  task t_rst;
    i_nrst = 0;
    @(negedge i_clock) chk(x, 10'h000);
    chk(y, 10'h000);
    i_nrst = 1;
    @(negedge i_clock) chk(x, 10'h001);
  endtask
  task t_col;
    while (x !== 10'h00A) @(negedge i_clock);
    i_mono_mode = 1; i_red = 4'hA;
    @(negedge i_clock) chk({2'h0, r, g}, 10'h0F0);
    chk({6'h00, b}, 10'h000);
    i_mono_mode = 0;
    @(negedge i_clock) chk({2'h0, r, g}, 10'h0A6);
    chk({6'h00, b}, 10'h003);
    while (x !== 10'h2BC) @(negedge i_clock);
    chk({2'h0, r, g}, 10'h000);
    chk({6'h00, b}, 10'h000);
  endtask
  initial begin
    repeat (2) @(negedge i_clock);
    chk(x, 10'h000);
    i_nrst = 1;
    t_line();
    t_col();
    t_rst();
    t_line();
    conclude();
  end
  initial begin
    #400000 errors++;
    conclude();
  end
endmodule // tb_vgatg_top
`default_nettype wire
